// ==== common/irq_defines.svh ====
// Constants of the input reference qualifier: offsets, fields, timing.
// Assumes a 10 MHz core clock and 32-bit APB data.
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH
// Core clock
`define IRQ_CLK_HZ 10000000
`define IRQ_CLK_PERIOD_NS 100
// Base timer step 1.25 ms, in ns, and its cycle count
`define IRQ_TICK_NS 1250000
`define IRQ_TICK_CYCLES (`IRQ_TICK_NS / `IRQ_CLK_PERIOD_NS)
// Lowest nominal frequency checked for activity
`define IRQ_ACT_MIN_HZ 1000
// Drop timer lengths in 1.25 ms steps: 2.5 s, 1.25 ms, 25 ms, 50 ms
`define IRQ_DROP_T0 16'd2000
`define IRQ_DROP_T1 16'd1
`define IRQ_DROP_T2 16'd20
`define IRQ_DROP_T3 16'd40
// Register byte offsets
`define IRQ_CFG_BASE 8'h00
`define IRQ_NOM_BASE 8'h10
`define IRQ_STAT_BASE 8'h20
`define IRQ_ALERT_MASK 8'h30
`define IRQ_PIN_MAP 8'h34
`define IRQ_INT_STAT 8'h38
`define IRQ_INT_CLR 8'h3c
`define IRQ_INT_EN 8'h40
`define IRQ_LOOP_SEL 8'h44
// Per-input configuration fields
`define IRQ_F_ACT_LSB 0
`define IRQ_F_DROP_LSB 3
`define IRQ_F_REQ_LSB 5
`define IRQ_F_OFS_LSB 7
`define IRQ_F_GAP_LSB 10
`define IRQ_F_ACT_DSQ 12
`define IRQ_F_LOS_DSQ 13
`define IRQ_F_FRQ_VAL 14
`define IRQ_CFG_RST 32'h0000_7000
`endif

// ==== common/irq_pkg.sv ====
// Types of the input reference qualifier.
// Constants live in irq_defines.svh.
package irq_pkg;
  // Qualification state of one input
  typedef enum logic [1:0] {
    IRQ_QUALIFIED,
    IRQ_DROP_WAIT,
    IRQ_DISQUAL,
    IRQ_REQUAL_WAIT
  } irq_state_type;
endpackage

// ==== hw/irq_qualifier.sv ====
// Input reference qualifier: activity, LOS, offset monitors and timers.
// Assumes reference clocks well below the core clock, APB master on core_clk.
//
// Operation
// - Activity checked only above 1 kHz
// - Three-bit selector picks activity ppm window
// - Activity alarm after out-of-window beyond drop time
// - Masked activity alarm feeds aggregated alert pin
// - Persistent alarm over drop timer disqualifies input
// - Per-alarm bits allow disqualification influence
// - Drop timer: 2.5s, 1.25ms, 25ms, 50ms
// - Requalify after alarms stay clear full period
// - Requalify period 4x, 2x, 8x, 16x drop
// - Offset beyond rejection range raises alarm
// - Offset alarm clears inside narrower acceptance range
// - Three-bit selector picks acceptance/rejection pair
// - Valid only with no alarms nor pins
// - Asserted mapped pin removes input from loops
// - Active input lost: switch to valid one
// - All inputs monitored continuously, active included
// - Gap setting sets missed clocks for LOS
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "irq_defines.svh"

module irq_qualifier #(
  parameter int N_IN = 4,              // Monitored inputs
  parameter int N_PIN = 4,             // Disqualify pins
  parameter int N_LOOP = 2,            // Loops served
  parameter int GATE_CYCLES = 1000000, // Measurement window
  parameter int TICK_CYCLES = `IRQ_TICK_CYCLES // Timer step
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [N_IN-1:0] ref_clk_in,
  input wire logic [N_PIN-1:0] dsq_pin_in,
  output logic [N_IN-1:0] input_valid,
  output logic [N_LOOP*2-1:0] active_ref,
  output logic [N_LOOP-1:0] switchover,
  output logic alert_out,
  output logic irq_out
);

  // Elaboration checks
  if (N_IN < 1 || N_IN > 4) $error("N_IN must be 1..4");
  if (N_PIN < 1 || N_PIN > 8) $error("N_PIN must be 1..8");
  if (N_LOOP < 1 || N_LOOP > 8) $error("N_LOOP must be 1..8");
  if (GATE_CYCLES < 2 || TICK_CYCLES < 1) $error("Bad timing parameters");

  localparam int NEV = 2 * N_IN + N_LOOP; // Interrupt event count

  // Activity window in tenths of ppm
  function automatic logic [13:0] activity_window_sel(input logic [2:0] s);
    case (s)
      3'h0: activity_window_sel = 14'd10000;
      3'h1: activity_window_sel = 14'd2600;
      3'h2: activity_window_sel = 14'd1300;
      3'h3: activity_window_sel = 14'd830;
      3'h4: activity_window_sel = 14'd650;
      3'h5: activity_window_sel = 14'd520;
      3'h6: activity_window_sel = 14'd180;
      default: activity_window_sel = 14'd120;
    endcase
  endfunction

  // Offset ranges in tenths of ppm: {acceptance, rejection}
  function automatic logic [27:0] ofs_lim(input logic [2:0] s);
    case (s)
      3'h0: ofs_lim = {14'd92, 14'd120};
      3'h1: ofs_lim = {14'd138, 14'd180};
      3'h2: ofs_lim = {14'd246, 14'd320};
      3'h3: ofs_lim = {14'd366, 14'd475};
      3'h4: ofs_lim = {14'd400, 14'd520};
      3'h5: ofs_lim = {14'd520, 14'd675};
      3'h6: ofs_lim = {14'd640, 14'd830};
      default: ofs_lim = {14'd1000, 14'd1300};
    endcase
  endfunction

  // Drop timer length in ticks
  function automatic logic [15:0] drop_len(input logic [1:0] s);
    case (s)
      2'h0: drop_len = `IRQ_DROP_T0;
      2'h1: drop_len = `IRQ_DROP_T1;
      2'h2: drop_len = `IRQ_DROP_T2;
      default: drop_len = `IRQ_DROP_T3;
    endcase
  endfunction

  // Requalify length: drop length times 4, 2, 8 or 16
  function automatic logic [19:0] req_len(input logic [1:0] m,
                                          input logic [15:0] d);
    case (m)
      2'h0: req_len = {2'h0, d, 2'h0};
      2'h1: req_len = {3'h0, d, 1'h0};
      2'h2: req_len = {1'h0, d, 3'h0};
      default: req_len = {d, 4'h0};
    endcase
  endfunction

  // True when |diff| * 1e7 exceeds limit * nominal
  function automatic logic beyond(input logic [23:0] meas,
                                  input logic [23:0] nom,
                                  input logic [13:0] lim);
    logic [23:0] diff;
    logic [63:0] lhs;
    logic [63:0] rhs;
    diff = (meas > nom) ? meas - nom : nom - meas;
    lhs = 64'(diff) * 64'd10000000;
    rhs = 64'(lim) * 64'(nom);
    beyond = lhs > rhs;
  endfunction

  // Registers
  logic [31:0] cfg_q [N_IN];     // Per-input configuration
  logic [23:0] nom_q [N_IN];     // Expected edges per window
  logic [N_IN-1:0] alert_mask_q; // Alert contributors
  logic [31:0] pin_map_q;        // Per pin: enable and input index
  logic [NEV-1:0] int_stat_q;    // Sticky events
  logic [NEV-1:0] int_en_q;      // Event enables
  // Monitor state
  logic [23:0] meas_q [N_IN];    // Last measured edge count
  logic [N_IN-1:0] act_alarm_q;
  logic [N_IN-1:0] los_q;
  logic [N_IN-1:0] frq_alarm_q;
  irq_pkg::irq_state_type st_q [N_IN];
  logic [N_IN-1:0] dsq_ev;       // Disqualify event pulses
  logic [N_IN-1:0] req_ev;       // Requalify event pulses
  logic [N_IN-1:0] pin_dsq;      // Inputs removed by pins
  logic [N_LOOP-1:0] sw_ev;      // Switchover pulses
  logic [2:0] dsq_s1_q [N_PIN];  // Pin synchroniser chains
  logic [N_PIN-1:0] dsq_lvl_q;   // Agreed pin levels

  // Shared measurement window and timer step
  logic [31:0] gate_cnt_q;
  logic gate_end;
  logic [31:0] tick_cnt_q;
  logic tick;
  assign gate_end = gate_cnt_q == 32'(GATE_CYCLES - 1);
  assign tick = tick_cnt_q == 32'(TICK_CYCLES - 1);

  // Window and step counters; steps bound timer resolution to 1.25 ms
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gate_cnt_q <= 32'h0;
      tick_cnt_q <= 32'h0;
    end else begin
      gate_cnt_q <= gate_end ? 32'h0 : gate_cnt_q + 32'h1;
      tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
    end
  end

  // APB write strobe and decode
  logic wr;
  logic [7:0] wa;
  assign wr = psel && penable && pwrite;
  assign wa = paddr;

  // Per-input monitors, all running at once
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_in
      logic [2:0] sy_q;       // Three-stage synchroniser
      logic lvl_q;            // Agreed level
      logic edge_d;
      logic [23:0] ecnt_q;    // Edges in the current window
      logic [31:0] gap_q;     // Cycles since last edge
      logic [15:0] act_tmr_q; // Out-of-window persistence
      logic [19:0] tmr_q;     // Drop / requalify timer
      logic act_raw;
      logic act_on;
      logic gated;
      logic [1:0] miss;
      logic [15:0] dlen;
      logic [27:0] olim;      // Offset limits: {acceptance, rejection}

      assign edge_d = (sy_q[1] == sy_q[2]) && sy_q[2] && !lvl_q;
      assign dlen = drop_len(cfg_q[gi][`IRQ_F_DROP_LSB +: 2]);
      // Activity only for inputs above 1 kHz
      assign act_on = 64'(nom_q[gi]) * 64'(`IRQ_CLK_HZ) >
                      64'(`IRQ_ACT_MIN_HZ) * 64'(GATE_CYCLES);
      assign act_raw = act_on && beyond(meas_q[gi], nom_q[gi],
                       activity_window_sel(cfg_q[gi][`IRQ_F_ACT_LSB +: 3]));
      // Only enabled alarms steer the drop decision
      assign gated = (act_alarm_q[gi] && cfg_q[gi][`IRQ_F_ACT_DSQ]) ||
                     (los_q[gi] && cfg_q[gi][`IRQ_F_LOS_DSQ]);
      assign miss = cfg_q[gi][`IRQ_F_GAP_LSB +: 2];
      // Decoded once so each half can be sliced from a plain signal
      assign olim = ofs_lim(cfg_q[gi][`IRQ_F_OFS_LSB +: 3]);

      // Synchronise and count edges; second and third stage must agree
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          sy_q <= 3'h0;
          lvl_q <= 1'b0;
          ecnt_q <= 24'h0;
          meas_q[gi] <= 24'h0;
        end else begin
          sy_q <= {sy_q[1:0], ref_clk_in[gi]};
          if (sy_q[1] == sy_q[2]) begin
            lvl_q <= sy_q[2];
          end
          // Window close latches the count, active input too
          if (gate_end) begin
            meas_q[gi] <= ecnt_q;
            ecnt_q <= {23'h0, edge_d};
          end else if (edge_d) begin
            ecnt_q <= ecnt_q + 24'h1;
          end
        end
      end

      // LOS after the set number of missed periods
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          gap_q <= 32'h0;
          los_q[gi] <= 1'b0;
        end else begin
          gap_q <= edge_d ? 32'h0 : gap_q + {31'h0, ~&gap_q};
          if (edge_d) begin
            los_q[gi] <= 1'b0;
          end else if (nom_q[gi] != 24'h0) begin
            // Off (00) falls back to a one-period check
            los_q[gi] <= 64'(gap_q) * 64'(nom_q[gi]) >
                         64'(GATE_CYCLES) *
                         ((miss == 2'h3) ? 64'd5 :
                          (miss == 2'h2) ? 64'd2 : 64'd1);
          end
        end
      end

      // Offset alarm with hysteresis between the two ranges
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          frq_alarm_q[gi] <= 1'b0;
        end else if (gate_end && nom_q[gi] != 24'h0) begin
          if (beyond(meas_q[gi], nom_q[gi], olim[13:0])) begin
            frq_alarm_q[gi] <= 1'b1;
          end else if (!beyond(meas_q[gi], nom_q[gi], olim[27:14])) begin
            frq_alarm_q[gi] <= 1'b0;
          end
        end
      end

      // Activity alarm only after out-of-window for the drop time
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          act_tmr_q <= 16'h0;
          act_alarm_q[gi] <= 1'b0;
        end else if (!act_raw) begin
          act_tmr_q <= 16'h0;
          act_alarm_q[gi] <= 1'b0;
        end else if (tick && !act_alarm_q[gi]) begin
          act_tmr_q <= act_tmr_q + 16'h1;
          if (act_tmr_q + 16'h1 >= dlen) begin
            act_alarm_q[gi] <= 1'b1;
          end
        end
      end

      // Qualification state machine
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          st_q[gi] <= irq_pkg::IRQ_QUALIFIED;
          tmr_q <= 20'h0;
          dsq_ev[gi] <= 1'b0;
          req_ev[gi] <= 1'b0;
        end else begin
          dsq_ev[gi] <= 1'b0;
          req_ev[gi] <= 1'b0;
          case (st_q[gi])
            irq_pkg::IRQ_QUALIFIED: begin
              // Alarm seen: start the drop timer
              if (gated) begin
                st_q[gi] <= irq_pkg::IRQ_DROP_WAIT;
                tmr_q <= 20'h0;
              end
            end
            irq_pkg::IRQ_DROP_WAIT: begin
              if (!gated) begin
                st_q[gi] <= irq_pkg::IRQ_QUALIFIED;
              end else if (tick) begin
                tmr_q <= tmr_q + 20'h1;
                if (tmr_q + 20'h1 >= {4'h0, dlen}) begin
                  st_q[gi] <= irq_pkg::IRQ_DISQUAL;
                  dsq_ev[gi] <= 1'b1;
                end
              end
            end
            irq_pkg::IRQ_DISQUAL: begin
              // Alarms gone: start the requalify timer
              if (!gated) begin
                st_q[gi] <= irq_pkg::IRQ_REQUAL_WAIT;
                tmr_q <= 20'h0;
              end
            end
            irq_pkg::IRQ_REQUAL_WAIT: begin
              if (gated) begin
                st_q[gi] <= irq_pkg::IRQ_DISQUAL;
              end else if (tick) begin
                tmr_q <= tmr_q + 20'h1;
                if (tmr_q + 20'h1 >= req_len(
                    cfg_q[gi][`IRQ_F_REQ_LSB +: 2], dlen)) begin
                  st_q[gi] <= irq_pkg::IRQ_QUALIFIED;
                  req_ev[gi] <= 1'b1;
                end
              end
            end
            default: st_q[gi] <= irq_pkg::IRQ_DISQUAL;
          endcase
        end
      end

      // Valid only when qualified, offset clean and no pin asserted
      assign input_valid[gi] = st_q[gi] == irq_pkg::IRQ_QUALIFIED &&
          !(frq_alarm_q[gi] && cfg_q[gi][`IRQ_F_FRQ_VAL]) &&
          !pin_dsq[gi];
    end
  endgenerate

  // Disqualify pins: three flip-flops, level once stages two/three agree
  genvar gp;
  generate
    for (gp = 0; gp < N_PIN; gp++) begin : g_pin
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          dsq_s1_q[gp] <= 3'h0;
          dsq_lvl_q[gp] <= 1'b0;
        end else begin
          dsq_s1_q[gp] <= {dsq_s1_q[gp][1:0], dsq_pin_in[gp]};
          if (dsq_s1_q[gp][1] == dsq_s1_q[gp][2]) begin
            dsq_lvl_q[gp] <= dsq_s1_q[gp][2];
          end
        end
      end
    end
  endgenerate

  // Map asserted pins onto inputs
  always_comb begin
    pin_dsq = '0;
    for (int p = 0; p < N_PIN; p++) begin
      if (pin_map_q[4*p+3] && dsq_lvl_q[p]) begin
        pin_dsq[pin_map_q[4*p +: 2]] = 1'b1;
      end
    end
  end

  // First valid input, for switchover
  logic [1:0] first_valid;
  always_comb begin
    first_valid = 2'h0;
    for (int i = N_IN - 1; i >= 0; i--) begin
      if (input_valid[i]) begin
        first_valid = 2'(i);
      end
    end
  end

  // Loop reference selection; software write, else hardware switchover
  logic [N_LOOP*2-1:0] active_q;
  genvar gl;
  generate
    for (gl = 0; gl < N_LOOP; gl++) begin : g_loop
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          active_q[2*gl +: 2] <= 2'h0;
          sw_ev[gl] <= 1'b0;
        end else begin
          sw_ev[gl] <= 1'b0;
          if (wr && wa == `IRQ_LOOP_SEL) begin
            active_q[2*gl +: 2] <= pwdata[2*gl +: 2];
          end else if (!input_valid[active_q[2*gl +: 2]] &&
                       |input_valid) begin
            active_q[2*gl +: 2] <= first_valid;
            sw_ev[gl] <= 1'b1;
          end
        end
      end
    end
  endgenerate
  assign active_ref = active_q;
  assign switchover = sw_ev;

  // Configuration registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < N_IN; i++) begin
        cfg_q[i] <= `IRQ_CFG_RST;
        nom_q[i] <= 24'h0;
      end
      alert_mask_q <= '0;
      pin_map_q <= 32'h0;
      int_en_q <= '0;
    end else if (wr) begin
      for (int i = 0; i < N_IN; i++) begin
        if (wa == `IRQ_CFG_BASE + 8'(4 * i)) begin
          cfg_q[i] <= pwdata;
        end
        if (wa == `IRQ_NOM_BASE + 8'(4 * i)) begin
          nom_q[i] <= pwdata[23:0];
        end
      end
      if (wa == `IRQ_ALERT_MASK) begin
        alert_mask_q <= pwdata[N_IN-1:0];
      end
      if (wa == `IRQ_PIN_MAP) begin
        pin_map_q <= pwdata;
      end
      if (wa == `IRQ_INT_EN) begin
        int_en_q <= pwdata[NEV-1:0];
      end
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  logic [NEV-1:0] ev_all;
  logic [NEV-1:0] clr;
  assign ev_all = {sw_ev, req_ev, dsq_ev};
  assign clr = (wr && wa == `IRQ_INT_CLR) ? pwdata[NEV-1:0] : '0;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      int_stat_q <= '0;
    end else begin
      int_stat_q <= (int_stat_q & ~clr) | ev_all;
    end
  end
  assign irq_out = |(int_stat_q & int_en_q);

  // Masked activity alarms form the aggregated alert
  assign alert_out = |(act_alarm_q & alert_mask_q);

  // Read mux and unmapped detect
  logic [31:0] rd_d;
  logic hit;
  always_comb begin
    rd_d = 32'h0;
    hit = 1'b1;
    case (wa)
      `IRQ_ALERT_MASK: rd_d = 32'(alert_mask_q);
      `IRQ_PIN_MAP: rd_d = pin_map_q;
      `IRQ_INT_STAT: rd_d = 32'(int_stat_q);
      `IRQ_INT_CLR: rd_d = 32'h0;
      `IRQ_INT_EN: rd_d = 32'(int_en_q);
      `IRQ_LOOP_SEL: rd_d = 32'(active_q);
      default: hit = 1'b0;
    endcase
    for (int i = 0; i < N_IN; i++) begin
      if (wa == `IRQ_CFG_BASE + 8'(4 * i)) begin
        rd_d = cfg_q[i];
        hit = 1'b1;
      end
      if (wa == `IRQ_NOM_BASE + 8'(4 * i)) begin
        rd_d = {8'h0, nom_q[i]};
        hit = 1'b1;
      end
      // Status: activity, LOS, offset, qualified, measured count
      if (wa == `IRQ_STAT_BASE + 8'(4 * i)) begin
        rd_d = {meas_q[i], 3'h0, input_valid[i],
                st_q[i] == irq_pkg::IRQ_QUALIFIED, frq_alarm_q[i],
                los_q[i], act_alarm_q[i]};
        hit = 1'b1;
      end
    end
  end

  // Zero-wait APB answer; read data registered in the setup phase
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= rd_d;
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Assertions
  property p_irq_sticky;
    @(posedge core_clk) disable iff (!rst_b)
      |ev_all |=> |int_stat_q;
  endproperty
  a_irq_sticky: assert property (p_irq_sticky)
    else $error("Event not captured");
  property p_alert;
    @(posedge core_clk) disable iff (!rst_b)
      alert_out == |(act_alarm_q & alert_mask_q);
  endproperty
  a_alert: assert property (p_alert)
    else $error("Alert mismatch");
  property p_pin_dsq;
    @(posedge core_clk) disable iff (!rst_b)
      (pin_map_q[3] && pin_map_q[1:0] == 2'h1 && dsq_lvl_q[0]) |->
        !input_valid[1];
  endproperty
  a_pin_dsq: assert property (p_pin_dsq)
    else $error("Pin-removed input still valid");
  property p_switch;
    @(posedge core_clk) disable iff (!rst_b)
      (!input_valid[active_q[1:0]] && |input_valid &&
       !(wr && wa == `IRQ_LOOP_SEL)) |=> sw_ev[0];
  endproperty
  a_switch: assert property (p_switch)
    else $error("No switchover");
  property p_valid_q;
    @(posedge core_clk) disable iff (!rst_b)
      input_valid[0] |-> st_q[0] == irq_pkg::IRQ_QUALIFIED;
  endproperty
  a_valid_q: assert property (p_valid_q)
    else $error("Valid while not qualified");
  property p_dsq_from_wait;
    @(posedge core_clk) disable iff (!rst_b)
      dsq_ev[0] |-> $past(st_q[0]) == irq_pkg::IRQ_DROP_WAIT;
  endproperty
  a_dsq_from_wait: assert property (p_dsq_from_wait)
    else $error("Disqualify without drop wait");
  property p_req_from_wait;
    @(posedge core_clk) disable iff (!rst_b)
      req_ev[0] |-> $past(st_q[0]) == irq_pkg::IRQ_REQUAL_WAIT;
  endproperty
  a_req_from_wait: assert property (p_req_from_wait)
    else $error("Requalify without wait");
  property p_frq_hold;
    @(posedge core_clk) disable iff (!rst_b)
      !gate_end |=> $stable(frq_alarm_q);
  endproperty
  a_frq_hold: assert property (p_frq_hold)
    else $error("Offset alarm moved off window edge");
  property p_irq_out;
    @(posedge core_clk) disable iff (!rst_b)
      (|(ev_all & int_en_q)) |=> irq_out;
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("Interrupt not raised");
  c_dsq: cover property (@(posedge core_clk) disable iff (!rst_b)
    dsq_ev[0]);
  c_req: cover property (@(posedge core_clk) disable iff (!rst_b)
    req_ev[0]);
  c_sw: cover property (@(posedge core_clk) disable iff (!rst_b)
    sw_ev[0]);

endmodule
`default_nettype wire

// ==== tb/irq_ref_model.sv ====
// Reference clock source model for the qualifier bench.
// Assumes core_clk drives it; its clocks are phase-locked to core_clk.
`timescale 1ns/100ps
`default_nettype none
module irq_ref_model #(
  parameter int N = 4 // Clock outputs
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [N*8-1:0] half_per, // Half period in cycles, 0 stops
  output logic [N-1:0] ref_clk
);
  // One divider per input; whole periods keep edges per window exact
  for (genvar i = 0; i < N; i++) begin : g_src
    logic [7:0] cnt_q; // Cycles into the half period
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        cnt_q <= 8'h00;
        ref_clk[i] <= 1'b0;
      end else if (half_per[i*8 +: 8] == 8'h00) begin // Stopped: idle low
        cnt_q <= 8'h00;
        ref_clk[i] <= 1'b0;
      end else if (cnt_q >= half_per[i*8 +: 8] - 8'h01) begin // Toggle
        cnt_q <= 8'h00;
        ref_clk[i] <= ~ref_clk[i];
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/input_reference_qualifier_tb_top.sv ====
// Self-checking bench of the qualifier over APB.
// Assumes short timers: 4-cycle tick, 200-cycle measurement window.
`timescale 1ns/100ps
`default_nettype none
`include "irq_defines.svh"
module input_reference_qualifier_tb_top;
  logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic alert_out, irq_out, last_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, half_per, d;
  logic [3:0] ref_clk, dsq, input_valid, active_ref;
  logic [1:0] switchover;
  int num_errors, cmp_count, n, c;
  irq_qualifier #(.GATE_CYCLES(200), .TICK_CYCLES(4)) i_dut (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_clk_in(ref_clk),
    .dsq_pin_in(dsq), .input_valid(input_valid), .active_ref(active_ref),
    .switchover(switchover), .alert_out(alert_out), .irq_out(irq_out));
  irq_ref_model #(.N(4)) i_src (.core_clk(core_clk), .rst_b(rst_b),
    .half_per(half_per), .ref_clk(ref_clk));
  // 10 MHz clock
  always #50 core_clk = ~core_clk;
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One APB transfer; waits for pready, bounded
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 100) begin
      num_errors++;
      results();
    end
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    xfer(1'b1, a, v, x);
  endtask
  // Read until masked value matches, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    int k;
    logic [31:0] x;
    k = 0;
    do begin
      xfer(1'b0, a, 32'h0, x);
      k++;
    end while ((x & m) !== e && k < 3000);
    chk(x & m, e);
    if ((x & m) !== e) results();
  endtask
  initial begin
    core_clk = 0; rst_b = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h00; pwdata = 32'h0; half_per = 32'h0; dsq = 4'h0;
    num_errors = 0; cmp_count = 0;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    // Reset values and a refused access
    chk(irq_out, 0);
    poll(`IRQ_CFG_BASE, 32'hffffffff, `IRQ_CFG_RST);
    xfer(1'b0, 8'h48, 32'h0, d);
    chk({31'h0, last_err}, 32'h1);
    chk(d, 32'h0);
    chk({31'h0, pready}, 32'h1);
    // Input 0 at 10 edges per window, short timers
    half_per <= 32'h0000_000a;
    wr(`IRQ_NOM_BASE, 32'h0000_000a);
    wr(`IRQ_CFG_BASE, 32'h0000_7028);
    wr(`IRQ_INT_EN, 32'h0000_03ff);
    wr(`IRQ_ALERT_MASK, 32'h1);
    poll(`IRQ_STAT_BASE, 32'hffffff1f, 32'h0000_0a18);
    wr(`IRQ_INT_CLR, 32'h0000_03ff);
    chk(irq_out, 0);
    // Clock stops: LOS, activity alarm, disqualify
    half_per <= 32'h0;
    poll(`IRQ_STAT_BASE, 32'h1b, 32'h03);
    chk(input_valid[0], 0);
    chk(alert_out, 1);
    wr(`IRQ_ALERT_MASK, 32'h0);
    chk(alert_out, 0);
    poll(`IRQ_INT_STAT, 32'h1, 32'h1);
    chk(irq_out, 1);
    wr(`IRQ_INT_CLR, 32'h1);
    poll(`IRQ_INT_STAT, 32'h1, 32'h0);
    // Clock returns: requalified
    half_per <= 32'h0000_000a;
    poll(`IRQ_STAT_BASE, 32'h1f, 32'h18);
    poll(`IRQ_INT_STAT, 32'h10, 32'h10);
    // Every offset and activity code: off-frequency then back
    for (c = 0; c < 8; c++) begin
      wr(`IRQ_CFG_BASE, 32'h0000_7028 | (c << 7) | c);
      half_per <= 32'h0000_000c;
      poll(`IRQ_STAT_BASE, 32'h14, 32'h04);
      half_per <= 32'h0000_000a;
      poll(`IRQ_STAT_BASE, 32'h14, 32'h10);
    end
    // Pin 0 removes input 1, which loop 0 is using
    wr(`IRQ_PIN_MAP, 32'h0000_0009);
    wr(`IRQ_LOOP_SEL, 32'h1);
    dsq <= 4'h1;
    n = 0;
    while (switchover[0] !== 1'b1 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    chk({31'h0, switchover[0]}, 32'h1);
    if (n >= 2000) results();
    chk(active_ref[1:0], 0);
    chk(input_valid[1], 0);
    @(posedge core_clk);
    poll(`IRQ_INT_STAT, 32'h100, 32'h100);
    dsq <= 4'h0;
    poll(`IRQ_STAT_BASE + 8'h04, 32'h10, 32'h10);
    results();
  end
endmodule
`default_nettype wire
